// ### smb_slave_end.sv
// Purpose: slave end of the two-wire link, address, command and data bytes
// Assumes: serial lines arrive asynchronous to clock
// Notes: address strap is a two-bit level code, written bytes after the command byte go via a FIFO
`timescale 1ns/1ps
module smb_slave_end
    import smb_pkg::*;
#(
    parameter int TIMEOUT_CYC = TIMEOUT_CYC_DEF,
    parameter int FILT = FILT_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // link
    smb_if.slave bus,
    // address strap level
    input wire logic [1:0] addrSel,
    // command byte
    output logic [7:0] cmdByte,
    output logic cmdStrobe,
    // written data stream
    output logic wrValid,
    input wire logic wrReady,
    output logic [7:0] wrData,
    // read data
    input wire logic [7:0] rdByte,
    output logic rdStrobe,
    // address state
    output logic addrLatched,
    output logic [6:0] slaveAddr
);
    localparam int FW = $clog2(FILT + 1);

    if (TIMEOUT_CYC < 2 || FILT < 1) begin : g_chk
        $error("smb_slave_end: timeout and filter counts must be positive");
    end

    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_ADDR = 7'h02,
        S_AACK = 7'h04,
        S_WR = 7'h08,
        S_WACK = 7'h10,
        S_RD = 7'h20,
        S_RACK = 7'h40
    } smb_sst_t;

    // ----------------------------------------
    // line conditioning
    // ----------------------------------------
    logic [1:0] raw, filt;
    logic sclF, sdaF, sclQ, sdaQ;
    assign raw = {bus.scl, bus.sda};

    for (genvar i = 0; i < 2; i++) begin : g_filt
        logic q1, q2, f, next_f;
        logic [FW-1:0] c, next_c;
        always_comb begin
            next_f = f;
            next_c = c + 1'b1;
            if (q2 == f) begin
                next_c = '0;
            end else if (c == FW'(FILT - 1)) begin
                next_f = q2;
                next_c = '0;
            end
        end
        always_ff @(posedge clock) begin
            if (rst) begin
                q1 <= 1'b1;
                q2 <= 1'b1;
                f <= 1'b1;
                c <= '0;
            end else begin
                q1 <= raw[i];
                q2 <= q1;
                f <= next_f;
                c <= next_c;
            end
        end
        assign filt[i] = f;
    end

    assign sclF = filt[1];
    assign sdaF = filt[0];

    // edge and condition detection
    logic sclRise, sclFall, startEv, stopEv, timeout;
    assign sclRise = sclF && !sclQ;
    assign sclFall = !sclF && sclQ;
    assign startEv = sclF && sclQ && sdaQ && !sdaF;
    assign stopEv = sclF && sclQ && !sdaQ && sdaF;

    // strap sampled through two flops
    logic [1:0] selS1, selS2;
    logic [1:0] selLsb;
    assign selLsb = (selS2 == SEL_HIGH) ? LSB_HIGH :
                    (selS2 == SEL_MID) ? LSB_MID : LSB_LOW;

    // ----------------------------------------
    // stuck-line timeout
    // ----------------------------------------
    logic [31:0] lowCnt, next_lowCnt;
    always_comb begin
        if (sclF && sdaF) begin
            next_lowCnt = '0;
        end else if (lowCnt == 32'(TIMEOUT_CYC)) begin
            next_lowCnt = lowCnt;
        end else begin
            next_lowCnt = lowCnt + 32'h1;
        end
    end
    assign timeout = lowCnt == 32'(TIMEOUT_CYC);

    // ----------------------------------------
    // byte engine
    // ----------------------------------------
    smb_sst_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] shift, next_shift, tx, next_tx, next_cmdByte;
    logic sdaOe, next_sdaOe, isRead, next_isRead, cmdSeen, next_cmdSeen;
    logic next_latched, next_cmdStrobe, next_rdStrobe, push, fifoReady;
    logic [6:0] next_slaveAddr, want;

    assign want = addrLatched ? slaveAddr : {ADDR_HI, selLsb};

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shift = shift;
        next_tx = tx;
        next_sdaOe = sdaOe;
        next_isRead = isRead;
        next_cmdSeen = cmdSeen;
        next_cmdByte = cmdByte;
        next_latched = addrLatched;
        next_slaveAddr = slaveAddr;
        next_cmdStrobe = 1'b0;
        next_rdStrobe = 1'b0;
        push = 1'b0;
        if (timeout || stopEv) begin
            next_state = S_IDLE;
            next_sdaOe = 1'b0;
        end else if (startEv) begin
            next_state = S_ADDR;
            next_cnt = '0;
            next_sdaOe = 1'b0;
            next_cmdSeen = 1'b0;
        end else begin
            unique case (state)
                S_IDLE: begin
                end
                S_ADDR, S_WR: begin
                    if (sclRise) begin
                        next_shift = {shift[6:0], sdaF};
                        next_cnt = cnt + 4'h1;
                    end else if (sclFall && cnt == 4'h8) begin
                        next_state = S_IDLE;
                        if (state == S_ADDR) begin
                            if (!addrLatched && shift[7:3] == ADDR_HI) begin
                                next_latched = 1'b1;
                                next_slaveAddr = {ADDR_HI, selLsb};
                            end
                            if (shift[7:1] == want) begin
                                next_sdaOe = 1'b1;
                                next_isRead = shift[0];
                                next_state = S_AACK;
                            end
                        end else if (!cmdSeen) begin
                            next_cmdByte = shift;
                            next_cmdSeen = 1'b1;
                            next_cmdStrobe = 1'b1;
                            next_sdaOe = 1'b1;
                            next_state = S_WACK;
                        end else if (fifoReady) begin
                            push = 1'b1;
                            next_sdaOe = 1'b1;
                            next_state = S_WACK;
                        end
                    end
                end
                S_AACK, S_WACK: begin
                    if (sclFall) begin
                        next_cnt = '0;
                        if (state == S_AACK && isRead) begin
                            next_tx = rdByte;
                            next_rdStrobe = 1'b1;
                            next_sdaOe = !rdByte[7];
                            next_state = S_RD;
                        end else begin
                            next_sdaOe = 1'b0;
                            next_state = S_WR;
                        end
                    end
                end
                S_RD: begin
                    if (sclRise) begin
                        next_cnt = cnt + 4'h1;
                        next_tx = {tx[6:0], 1'b1};
                    end else if (sclFall) begin
                        next_sdaOe = (cnt == 4'h8) ? 1'b0 : !tx[7];
                        if (cnt == 4'h8) begin
                            next_state = S_RACK;
                        end
                    end
                end
                S_RACK: begin
                    if (sclRise) begin
                        next_cnt = '0;
                        if (sdaF) begin
                            next_state = S_IDLE;
                        end
                    end else if (sclFall && cnt == 4'h0) begin
                        next_tx = rdByte;
                        next_rdStrobe = 1'b1;
                        next_sdaOe = !rdByte[7];
                        next_state = S_RD;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sclQ <= 1'b1;
            sdaQ <= 1'b1;
            selS1 <= SEL_LOW;
            selS2 <= SEL_LOW;
            lowCnt <= '0;
            state <= S_IDLE;
            cnt <= '0;
            shift <= '0;
            tx <= '0;
            sdaOe <= 1'b0;
            isRead <= 1'b0;
            cmdSeen <= 1'b0;
            cmdByte <= '0;
            addrLatched <= 1'b0;
            slaveAddr <= '0;
            cmdStrobe <= 1'b0;
            rdStrobe <= 1'b0;
        end else begin
            sclQ <= sclF;
            sdaQ <= sdaF;
            selS1 <= addrSel;
            selS2 <= selS1;
            lowCnt <= next_lowCnt;
            state <= next_state;
            cnt <= next_cnt;
            shift <= next_shift;
            tx <= next_tx;
            sdaOe <= next_sdaOe;
            isRead <= next_isRead;
            cmdSeen <= next_cmdSeen;
            cmdByte <= next_cmdByte;
            addrLatched <= next_latched;
            slaveAddr <= next_slaveAddr;
            cmdStrobe <= next_cmdStrobe;
            rdStrobe <= next_rdStrobe;
        end
    end

    assign bus.sSdaO = 1'b0;
    assign bus.sSdaOe = sdaOe;

    // written data buffer, full fifo refuses the byte
    smb_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rst(rst),
        .inValid(push),
        .inReady(fifoReady),
        .inData(shift),
        .outValid(wrValid),
        .outReady(wrReady),
        .outData(wrData)
    );
endmodule // smb_slave_end

// ### smb_pkg.sv
// Purpose: shared constants for the two-wire slave port and its host
// Assumes: 125 MHz system clock, 100 kHz serial clock
// Notes: times are kept in their own unit, cycle counts derive from them
package smb_pkg;
    // ----------------------------------------
    // clocking and timing
    // ----------------------------------------
    localparam int CLK_NS = 8;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
    localparam int FILT_NS = 50;
    localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam int TIMEOUT_MS = 25;
    localparam int TIMEOUT_CYC_DEF = TIMEOUT_MS * 1000000 / CLK_NS;
    // ----------------------------------------
    // addressing and data path
    // ----------------------------------------
    localparam logic [4:0] ADDR_HI = 5'h0b;
    localparam logic [1:0] SEL_LOW = 2'h0;
    localparam logic [1:0] SEL_MID = 2'h1;
    localparam logic [1:0] SEL_HIGH = 2'h2;
    localparam logic [1:0] LSB_LOW = 2'h0;
    localparam logic [1:0] LSB_MID = 2'h2;
    localparam logic [1:0] LSB_HIGH = 2'h1;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 4;
endpackage

// ### smb_if.sv
// Purpose: open-drain serial clock and data wires between both ends
// Assumes: pull-ups on both wires, a driver only ever pulls low
// Notes: wire levels are resolved here from the enables
`timescale 1ns/1ps
interface smb_if;
    logic mSclO;
    logic mSclOe;
    logic mSdaO;
    logic mSdaOe;
    logic sSdaO;
    logic sSdaOe;
    logic scl;
    logic sda;

    // wired-and of all drivers with pull-up
    assign scl = !(mSclOe && !mSclO);
    assign sda = !(mSdaOe && !mSdaO) && !(sSdaOe && !sSdaO);

    modport master (output mSclO, output mSclOe, output mSdaO, output mSdaOe,
        input scl, input sda);
    modport slave (output sSdaO, output sSdaOe, input scl, input sda);
endinterface

// ### smb_fifo.sv
// Purpose: small flip-flop FIFO with valid and ready on both sides
// Assumes: depth is a power of two
// Notes: full and empty come straight from the fill count
`timescale 1ns/1ps
module smb_fifo
    import smb_pkg::*;
#(
    parameter int W = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [W-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [W-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_chk
        $error("smb_fifo: depth must be a power of two of at least 2");
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic [AW:0] count, next_count;
    logic push, pop;

    // honest full and empty
    assign inReady = count != (AW+1)'(DEPTH);
    assign outValid = count != '0;
    assign outData = mem[rdPtr];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // pointer and count update
    always_comb begin
        next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
        next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
        next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    // register stage
    always_ff @(posedge clock) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end
endmodule // smb_fifo

// ### smb_master_end.sv
// Purpose: host end, write byte and read byte transactions
// Assumes: slave never stretches the clock
// Notes: serial clock is divided from clock, four quarters per bit
`timescale 1ns/1ps
module smb_master_end
    import smb_pkg::*;
#(
    parameter int QTR = QTR_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // link
    smb_if.master bus,
    // request
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqRead,
    input wire logic [6:0] reqAddr,
    input wire logic [7:0] reqCmd,
    input wire logic [7:0] reqData,
    // response
    output logic respValid,
    output logic [7:0] respData,
    output logic respNack
);
    localparam int QW = $clog2(QTR + 1);

    if (QTR < 2) begin : g_chk
        $error("smb_master_end: quarter period too short");
    end

    typedef enum logic [3:0] {
        M_IDLE = 4'h1,
        M_START = 4'h2,
        M_BYTE = 4'h4,
        M_STOP = 4'h8
    } smb_mst_t;

    smb_mst_t state, next_state, k;
    logic [QW-1:0] qCnt, next_qCnt;
    logic [1:0] ph, next_ph;
    logic [3:0] bitIdx, next_bitIdx;
    logic [2:0] step, next_step;
    logic [7:0] tx, next_tx, rx, next_rx, cmd, next_cmd, data, next_data, b;
    logic [6:0] addr, next_addr;
    logic rd, next_rd, nack, next_nack, sclOe, next_sclOe, sdaOe, next_sdaOe;
    logic s1, s2, tick, enter, recvByte, next_respValid, next_respNack;
    logic [7:0] next_respData;

    // write command, then data byte, or repeated start and read
    function automatic smb_mst_t kindOf(input logic [2:0] s, input logic r);
        if (s == 3'h0 || (r && s == 3'h3)) begin
            kindOf = M_START;
        end else if (s == (r ? 3'h6 : 3'h4)) begin
            kindOf = M_STOP;
        end else begin
            kindOf = M_BYTE;
        end
    endfunction

    // quarter-period tick keeps clock at or below 100 kHz
    assign tick = qCnt == QW'(QTR - 1);
    assign reqReady = state == M_IDLE;
    assign recvByte = rd && step == 3'h5;
    assign k = kindOf(next_step, next_rd);
    // byte for the step being entered
    always_comb begin
        unique case (next_step)
            3'h1: b = {next_addr, 1'b0};
            3'h2: b = next_cmd;
            3'h3: b = next_data;
            3'h4: b = {next_addr, 1'b1};
            default: b = 8'hff;
        endcase
    end

    // sequencing of symbols and bits
    always_comb begin
        next_state = state;
        next_qCnt = (state == M_IDLE || tick) ? '0 : qCnt + 1'b1;
        next_ph = ph;
        next_bitIdx = bitIdx;
        next_step = step;
        next_tx = tx;
        next_rx = rx;
        next_rd = rd;
        next_addr = addr;
        next_cmd = cmd;
        next_data = data;
        next_nack = nack;
        next_sclOe = sclOe;
        next_sdaOe = sdaOe;
        next_respValid = 1'b0;
        next_respData = respData;
        next_respNack = respNack;
        enter = 1'b0;
        unique case (state)
            M_IDLE: begin
                if (reqValid) begin
                    next_rd = reqRead;
                    next_addr = reqAddr;
                    next_cmd = reqCmd;
                    next_data = reqData;
                    next_nack = 1'b0;
                    next_step = '0;
                    enter = 1'b1;
                end
            end
            default: begin
                if (tick && ph != 2'h3) begin
                    next_ph = ph + 2'h1;
                    if (state == M_BYTE) begin
                        // clock high in second half of each bit
                        next_sclOe = ph == 2'h0;
                        if (ph == 2'h2) begin
                            next_rx = (bitIdx < 4'h8) ? {rx[6:0], s2} : rx;
                            next_nack = nack || (bitIdx == 4'h8 && s2 && !recvByte);
                        end
                    end else if (ph == 2'h0) begin
                        next_sclOe = 1'b0;
                    end else if (ph == 2'h1) begin
                        next_sdaOe = state == M_START;
                    end
                end else if (tick) begin
                    if (state == M_BYTE && bitIdx != 4'h8) begin
                        // next bit set while clock low
                        next_bitIdx = bitIdx + 4'h1;
                        next_tx = {tx[6:0], 1'b1};
                        next_sdaOe = (bitIdx == 4'h7) ? 1'b0 : !tx[6];
                        next_sclOe = 1'b1;
                        next_ph = 2'h0;
                    end else if (state == M_STOP) begin
                        next_state = M_IDLE;
                        next_respValid = 1'b1;
                        next_respData = rx;
                        next_respNack = nack;
                    end else begin
                        next_step = nack ? (rd ? 3'h6 : 3'h4) : step + 3'h1;
                        enter = 1'b1;
                    end
                end
            end
        endcase
        if (enter) begin
            next_state = k;
            next_ph = 2'h0;
            next_bitIdx = '0;
            next_sclOe = 1'b1;
            next_tx = b;
            // pull data low ahead of stop
            next_sdaOe = (k == M_STOP) || (k == M_BYTE && !b[7]);
        end
    end

    // register stage
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= M_IDLE;
            qCnt <= '0;
            ph <= '0;
            bitIdx <= '0;
            step <= '0;
            tx <= '0;
            rx <= '0;
            rd <= 1'b0;
            addr <= '0;
            cmd <= '0;
            data <= '0;
            nack <= 1'b0;
            sclOe <= 1'b0;
            sdaOe <= 1'b0;
            s1 <= 1'b1;
            s2 <= 1'b1;
            respValid <= 1'b0;
            respData <= '0;
            respNack <= 1'b0;
        end else begin
            state <= next_state;
            qCnt <= next_qCnt;
            ph <= next_ph;
            bitIdx <= next_bitIdx;
            step <= next_step;
            tx <= next_tx;
            rx <= next_rx;
            rd <= next_rd;
            addr <= next_addr;
            cmd <= next_cmd;
            data <= next_data;
            nack <= next_nack;
            sclOe <= next_sclOe;
            sdaOe <= next_sdaOe;
            s1 <= bus.sda;
            s2 <= s1;
            respValid <= next_respValid;
            respData <= next_respData;
            respNack <= next_respNack;
        end
    end

    assign bus.mSclO = 1'b0;
    assign bus.mSclOe = sclOe;
    assign bus.mSdaO = 1'b0;
    assign bus.mSdaOe = sdaOe;
endmodule // smb_master_end

// ### smb_properties.sv
// Purpose: link checks between host and slave ends
// Assumes: one clock, sync active-high reset
// Notes: pos counts bits from START by clock falls
`timescale 1ns/1ps
module smb_properties (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // wire levels and enables
    input wire logic scl,
    input wire logic sda,
    input wire logic mSdaOe,
    input wire logic sSdaOe
);
    logic sclQ, sdaQ, first, rd, next_first, next_rd;
    logic [3:0] pos, next_pos;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // bit position and direction tracking
    always_comb begin
        next_pos = pos;
        next_first = first;
        next_rd = rd;
        if (sclQ && !scl) begin
            next_pos = (pos == 4'h8 || pos == 4'hf) ? 4'h0 : pos + 4'h1;
            next_first = first && pos != 4'h8;
        end
        if (!sclQ && scl && pos == 4'h7 && first) next_rd = sda;
        // start restarts the count
        if (sclQ && scl && sdaQ && !sda) begin
            next_pos = 4'hf;
            next_first = 1'b1;
            next_rd = 1'b0;
        end
    end
    // register tracking state
    always_ff @(posedge clock) begin
        if (rst) {pos, first, rd, sclQ, sdaQ} <= {4'hf, 4'h3};
        else {pos, first, rd, sclQ, sdaQ} <= {next_pos, next_first, next_rd, scl, sda};
    end
    a_start_master: assert property (scl && $fell(sda) |-> mSdaOe)
        else $error("start not made by host");
    a_ack_hold: assert property ($rose(scl) && sSdaOe |-> sSdaOe [*8])
        else $error("ack dropped in clock high");
    a_ack_pos: assert property ($rose(sSdaOe) && !rd |-> pos == 4'h8)
        else $error("slave pulled data outside ack slot");
    a_ack_drop: assert property ($fell(scl) && pos == 4'h8 && !rd |-> ##[1:24] !sSdaOe)
        else $error("ack not released after ninth clock");
    a_slave_chg: assert property ($changed(sSdaOe) |-> !scl)
        else $error("slave changed data while clock high");
    a_no_clash: assert property (scl && sSdaOe |-> !mSdaOe)
        else $error("both ends drive data");
    a_stop_release: assert property (scl && $rose(sda) |=> !sSdaOe [*8])
        else $error("slave drives after stop");
    a_rd_release: assert property (rd && !first && pos == 4'h8 && scl |-> !sSdaOe)
        else $error("slave drives read ack slot");
    // main scenarios
    c_write_ack: cover property ($rose(sSdaOe) && !rd);
    c_read_data: cover property (rd && !first && $rose(sSdaOe));
    c_stop: cover property (scl && $rose(sda));
endmodule // smb_properties

// ### tb.sv
// Purpose: host and slave ends joined, self-checking
// Assumes: short quarter and timeout values
// Notes: reset checks first, then rows, then strap and buffer cases
`timescale 1ns/1ps
module tb import smb_pkg::*; ;
    typedef struct {logic [1:0] sel; logic rd; logic [6:0] a; logic [7:0] c, d; logic nk;} smb_row_t;
    logic clock, rst, reqValid, reqRead, reqReady, respValid, respNack, wrValid, wrReady;
    logic addrLatched, cmdStrobe, rdStrobe;
    int nCmd = 0, nRd = 0;
    logic [1:0] addrSel;
    logic [6:0] reqAddr, slaveAddr;
    logic [7:0] reqCmd, reqData, rdByte, respData, cmdByte, wrData;
    logic [7:0] popped[$];
    int errors = 0, nCompared = 0, cyc = 0;
    smb_row_t rows[5] = '{'{SEL_HIGH, 0, 7'h2d, 8'h10, 8'ha5, 0}, '{SEL_LOW, 0, 7'h2c, 8'h11, 8'h5a, 1},
        '{SEL_LOW, 1, 7'h2d, 8'h12, 8'h3c, 0}, '{SEL_LOW, 0, 7'h2e, 8'h13, 8'h00, 1},
        '{SEL_LOW, 1, 7'h55, 8'h14, 8'hff, 1}};
    smb_if bus();
    smb_master_end #(.QTR(16)) u_smb_master_end (.clock(clock), .rst(rst), .bus(bus),
        .reqValid(reqValid), .reqReady(reqReady), .reqRead(reqRead), .reqAddr(reqAddr),
        .reqCmd(reqCmd), .reqData(reqData), .respValid(respValid), .respData(respData),
        .respNack(respNack));
    smb_slave_end #(.TIMEOUT_CYC(2000)) u_smb_slave_end (.clock(clock), .rst(rst), .bus(bus),
        .addrSel(addrSel), .cmdByte(cmdByte), .cmdStrobe(cmdStrobe), .wrValid(wrValid),
        .wrReady(wrReady), .wrData(wrData), .rdByte(rdByte), .rdStrobe(rdStrobe),
        .addrLatched(addrLatched),
        .slaveAddr(slaveAddr));
    smb_properties u_smb_properties (.clock(clock), .rst(rst), .scl(bus.scl), .sda(bus.sda),
        .mSdaOe(bus.mSdaOe), .sSdaOe(bus.sSdaOe));
    // clock, drained bytes and hang guard
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // sampled mid-cycle, where the drain handshake is settled
    always @(negedge clock) begin
        if (wrValid && wrReady) popped.push_back(wrData);
        if (cmdStrobe) nCmd++;
        if (rdStrobe) nRd++;
        cyc++;
        if (cyc == 80000) begin
            errors++;
            finish_test;
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("compared %0d mismatches %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic do_reset(input logic [1:0] sel);
        rst = 1'b1;
        addrSel = sel;
        repeat (8) @(posedge clock);
        #1 rst = 1'b0;
        repeat (20) @(posedge clock);
        #1;
    endtask
    // one host transaction, held until taken
    task automatic xfer(input logic r, input logic [6:0] a, input logic [7:0] c, input logic [7:0] d);
        {reqValid, reqRead, reqAddr, reqCmd, reqData, rdByte} = {1'b1, r, a, c, d, d};
        while (reqReady !== 1'b1) begin
            @(posedge clock);
            #1;
        end
        @(posedge clock);
        #1 reqValid = 1'b0;
        do begin
            @(posedge clock);
            #1;
        end while (respValid !== 1'b1);
    endtask
    initial begin
        {reqValid, reqRead, reqAddr, reqCmd, reqData, rdByte, wrReady} = {33'h0, 1'b1};
        do_reset(SEL_HIGH);
        chk({7'h0, addrLatched}, 8'h0);
        chk(cmdByte, 8'h0);
        chk({7'h0, reqReady}, 8'h1);
        $display("reset test done");
        foreach (rows[i]) begin
            addrSel = rows[i].sel;
            popped.delete();
            nCmd = 0;
            nRd = 0;
            xfer(rows[i].rd, rows[i].a, rows[i].c, rows[i].d);
            chk(8'(nCmd), {7'h0, !rows[i].nk});
            chk(8'(nRd), {7'h0, rows[i].rd && !rows[i].nk});
            chk({7'h0, respNack}, {7'h0, rows[i].nk});
            if (!rows[i].nk) chk(rows[i].rd ? respData : cmdByte, rows[i].rd ? rows[i].d : rows[i].c);
            if (!rows[i].nk && !rows[i].rd) chk(popped[0], rows[i].d);
            $display("row %0d done", i);
        end
        for (int s = 0; s < 2; s++) begin
            do_reset(s ? SEL_LOW : SEL_MID);
            xfer(1'b0, s ? 7'h2c : 7'h2e, 8'h01, 8'h80);
            chk({7'h0, respNack}, 8'h0);
            chk({1'b0, slaveAddr}, s ? 8'h2c : 8'h2e);
            $display("strap %0d done", s);
        end
        // fill buffer with drain stalled, fifth byte refused
        wrReady = 1'b0;
        popped.delete();
        for (int k = 0; k < 5; k++) begin
            xfer(1'b0, 7'h2c, 8'h20, 8'(k));
            chk({7'h0, respNack}, {7'h0, k == 4});
        end
        wrReady = 1'b1;
        repeat (10) @(posedge clock);
        chk(8'(popped.size()), 8'h4);
        for (int k = 0; k < 4; k++) chk(popped[k], 8'(k));
        $display("buffer test done");
        finish_test;
    end
endmodule // tb
